//--- ris_top.sv
// Remappable input select: selector registers on AHB-Lite, lock, shadow check, muxes.
// Assumes one 10 MHz clock, asynchronous active-low reset, synchronous pin inputs.
// Function
// - Codes 0 to 25 route that pin
// - Code 11111 drives input from ground
// - Register zero: irq1 selector bits 12-8
// - Register one: irq2 selector bits 4-0
// - Register three: timer3 high, timer2 low
// - Register seven: capture2 high, capture1 low
// - Register ten: capture8 high, capture7 low
// - Register eleven: fault A selector bits 4-0
// - Unimplemented bits read zero, ignore writes
// - Selectors reset to all ones
// - Unlock keys 46h, 57h, then lock write
// - Locked selector writes complete but change nothing
// - One-way config forbids clearing set lock
// - Shadow mismatch raises configuration reset
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module ris_top #(
    parameter int NPINS = ris_pkg::NUM_PINS
) (
    input  wire logic                      CLOCK,
    input  wire logic                      RST_N,
    input  wire logic                      HSEL,
    input  wire logic [ris_pkg::ADDR_W-1:0] HADDR,
    input  wire logic [1:0]                HTRANS,
    input  wire logic                      HWRITE,
    input  wire logic [2:0]                HSIZE,
    input  wire logic [31:0]               HWDATA,
    input  wire logic                      HREADY,
    output logic [31:0]                    HRDATA,
    output logic                           HREADYOUT,
    output logic                           HRESP,
    input  wire logic                      ONE_WAY_LOCK_CFG,
    input  wire logic [NPINS-1:0]          REMAPPABLE_PIN,
    output logic                           EXTERNAL_IRQ_1,
    output logic                           EXTERNAL_IRQ_2,
    output logic                           TIMER3_EXT_CLOCK,
    output logic                           TIMER2_EXT_CLOCK,
    output logic                           CAPTURE_1,
    output logic                           CAPTURE_2,
    output logic                           CAPTURE_7,
    output logic                           CAPTURE_8,
    output logic                           COMPARE_FAULT_A,
    output logic                           CONFIG_MISMATCH_RESET,
    output logic                           PIN_MAP_LOCK
);
    import ris_pkg::*;
    localparam int SELS_W = NUM_PERIPH * SEL_W;
    localparam logic [SELS_W-1:0] SELS_RESET = {NUM_PERIPH{SEL_RESET}};

    typedef struct packed {
        logic [SELS_W-1:0] sel;
        logic [SELS_W-1:0] shadow;
        logic              lock;
        ris_key_t          key;
        logic [7:0]        osc_low;
        logic              wr_pend;
        logic [5:0]        wr_idx;
        logic [31:0]       rdata;
        logic              mismatch;
    } ris_st_t;
    ris_st_t s_q;
    ris_st_t s_d;

    logic              addr_ok;
    logic [5:0]        a_idx;
    logic [31:0]       rd_word;
    logic [NUM_PERIPH-1:0] route;

    assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    assign a_idx   = HADDR[ADDR_W-1:2];

    function automatic logic [4:0] fsel(input logic [SELS_W-1:0] v, input int slot);
        fsel = v[slot*SEL_W +: SEL_W];
    endfunction

    // Read mux; unimplemented bits and unmapped addresses read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (a_idx)
            IDX_IRQ1:   rd_word[HI_LSB +: SEL_W] = fsel(s_q.sel, S_IRQ1);
            IDX_IRQ2:   rd_word[LO_LSB +: SEL_W] = fsel(s_q.sel, S_IRQ2);
            IDX_TIMER: begin
                rd_word[HI_LSB +: SEL_W] = fsel(s_q.sel, S_T3);
                rd_word[LO_LSB +: SEL_W] = fsel(s_q.sel, S_T2);
            end
            IDX_CAP12: begin
                rd_word[HI_LSB +: SEL_W] = fsel(s_q.sel, S_C2);
                rd_word[LO_LSB +: SEL_W] = fsel(s_q.sel, S_C1);
            end
            IDX_CAP78: begin
                rd_word[HI_LSB +: SEL_W] = fsel(s_q.sel, S_C8);
                rd_word[LO_LSB +: SEL_W] = fsel(s_q.sel, S_C7);
            end
            IDX_FAULT:  rd_word[LO_LSB +: SEL_W] = fsel(s_q.sel, S_FA);
            IDX_OSC: begin
                rd_word[7:0] = s_q.osc_low;
                rd_word[LOCK_BIT] = s_q.lock;
            end
            IDX_STATUS: rd_word[0] = s_q.mismatch;
            default:    rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        logic [4:0] hi;
        logic [4:0] lo;
        logic       wr_ok;
        logic [7:0] wb;
        s_d = s_q;
        hi = HWDATA[HI_LSB +: SEL_W];
        lo = HWDATA[LO_LSB +: SEL_W];
        wb = HWDATA[7:0];
        wr_ok = 1'b0;
        s_d.wr_pend = 1'b0;
        // Address phase: capture writes, serve reads in the following data phase
        if (addr_ok) begin
            s_d.wr_pend = HWRITE && (HSIZE == HSIZE_WORD);
            s_d.wr_idx  = a_idx;
            s_d.rdata   = rd_word;
        end
        // Data phase of a write
        if (s_q.wr_pend) begin
            wr_ok = !s_q.lock;
            unique case (s_q.wr_idx)
                IDX_IRQ1: if (wr_ok) s_d.sel[S_IRQ1*SEL_W +: SEL_W] = hi;
                IDX_IRQ2: if (wr_ok) s_d.sel[S_IRQ2*SEL_W +: SEL_W] = lo;
                IDX_TIMER: if (wr_ok) begin
                    s_d.sel[S_T3*SEL_W +: SEL_W] = hi;
                    s_d.sel[S_T2*SEL_W +: SEL_W] = lo;
                end
                IDX_CAP12: if (wr_ok) begin
                    s_d.sel[S_C2*SEL_W +: SEL_W] = hi;
                    s_d.sel[S_C1*SEL_W +: SEL_W] = lo;
                end
                IDX_CAP78: if (wr_ok) begin
                    s_d.sel[S_C8*SEL_W +: SEL_W] = hi;
                    s_d.sel[S_C7*SEL_W +: SEL_W] = lo;
                end
                IDX_FAULT: if (wr_ok) s_d.sel[S_FA*SEL_W +: SEL_W] = lo;
                IDX_OSC: begin
                    // Key sequence; any other write to this register closes it again
                    unique case (s_q.key)
                        KEY_IDLE: s_d.key = (wb == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
                        KEY_GOT1: s_d.key = (wb == KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
                        KEY_OPEN: begin
                            s_d.key = KEY_IDLE;
                            if (HWDATA[LOCK_BIT] || !(ONE_WAY_LOCK_CFG && s_q.lock)) begin
                                s_d.lock = HWDATA[LOCK_BIT];
                            end
                        end
                        default: s_d.key = KEY_IDLE;
                    endcase
                    s_d.osc_low = wb & ~(8'h01 << LOCK_BIT);
                end
                IDX_STATUS: s_d.mismatch = s_q.mismatch && !HWDATA[0];
                default: s_d.key = s_q.key;
            endcase
        end
        // Shadow follows only legitimate writes; a stray change is flagged
        s_d.shadow = s_d.sel;
        if (s_q.sel != s_q.shadow) begin
            s_d.mismatch = 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            s_q.sel      <= SELS_RESET;
            s_q.shadow   <= SELS_RESET;
            s_q.lock     <= 1'b0;
            s_q.key      <= KEY_IDLE;
            s_q.osc_low  <= 8'h00;
            s_q.wr_pend  <= 1'b0;
            s_q.wr_idx   <= 6'h00;
            s_q.rdata    <= 32'h0000_0000;
            s_q.mismatch <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // One registered multiplexer per peripheral input
    genvar g;
    generate
        for (g = 0; g < NUM_PERIPH; g++) begin : g_mux
            ris_mux #(.NPINS(NPINS)) u_mux (
                .clk   (CLOCK),
                .rst_n (RST_N),
                .pins  (REMAPPABLE_PIN),
                .sel   (s_q.sel[g*SEL_W +: SEL_W]),
                .q     (route[g])
            );
        end
    endgenerate

    assign EXTERNAL_IRQ_1        = route[S_IRQ1];
    assign EXTERNAL_IRQ_2        = route[S_IRQ2];
    assign TIMER3_EXT_CLOCK      = route[S_T3];
    assign TIMER2_EXT_CLOCK      = route[S_T2];
    assign CAPTURE_2             = route[S_C2];
    assign CAPTURE_1             = route[S_C1];
    assign CAPTURE_8             = route[S_C8];
    assign CAPTURE_7             = route[S_C7];
    assign COMPARE_FAULT_A       = route[S_FA];
    assign CONFIG_MISMATCH_RESET = s_q.mismatch;
    assign PIN_MAP_LOCK          = s_q.lock;
    assign HRDATA                = s_q.rdata;
    // Zero wait states keep the slave simple; every answer is OKAY
    assign HREADYOUT             = 1'b1;
    assign HRESP                 = 1'b0;

    lock_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_q.lock && !(s_q.wr_pend && s_q.wr_idx == IDX_OSC) |=> $stable(s_q.sel))
        else $error("selectors changed while locked");
    one_way_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        ONE_WAY_LOCK_CFG && s_q.lock |=> s_q.lock)
        else $error("one-way lock was cleared");
    ground_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        fsel(s_q.sel, S_FA) > SEL_MAX_PIN |=> !COMPARE_FAULT_A)
        else $error("out of range selector not grounded");
    route_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        fsel(s_q.sel, S_IRQ1) <= SEL_MAX_PIN
        |=> EXTERNAL_IRQ_1 == $past(REMAPPABLE_PIN[fsel(s_q.sel, S_IRQ1)]))
        else $error("irq1 routing wrong");
    key_open_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_q.key == KEY_OPEN |-> $past(s_q.key) == KEY_GOT1 || $past(s_q.key) == KEY_OPEN)
        else $error("lock opened without key");
    shadow_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_q.sel != s_q.shadow |=> CONFIG_MISMATCH_RESET)
        else $error("mismatch not flagged");
    // Checks the read word itself, so a read path that leaks stray bits is caught
    unimpl_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        addr_ok && !HWRITE && a_idx == IDX_IRQ1
        |=> HRDATA[7:0] == '0 && HRDATA[31:HI_LSB+SEL_W] == '0)
        else $error("unimplemented bits read nonzero");
    irq2_rd_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        addr_ok && !HWRITE && a_idx == IDX_IRQ2
        |=> HRDATA[31:SEL_W] == '0 && HRDATA[4:0] == $past(fsel(s_q.sel, S_IRQ2)))
        else $error("irq2 readback wrong");
endmodule

//--- ris_pkg.sv
// Package for the remappable input select block: register map, fields, reset values.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package ris_pkg;
    localparam int          SEL_W        = 5;
    localparam int          NUM_PINS     = 26;
    localparam int          NUM_PERIPH   = 9;
    localparam int          ADDR_W       = 8;
    localparam logic [4:0]  SEL_MAX_PIN  = 5'h19;
    localparam logic [4:0]  SEL_GROUND   = 5'h1F;
    localparam logic [4:0]  SEL_RESET    = 5'h1F;
    localparam logic [7:0]  KEY_FIRST    = 8'h46;
    localparam logic [7:0]  KEY_SECOND   = 8'h57;
    localparam int          LOCK_BIT     = 6;
    localparam int          HI_LSB       = 8;
    localparam int          LO_LSB       = 0;
    // Register indices; byte address is four times the index
    localparam logic [5:0]  IDX_IRQ1     = 6'h00;
    localparam logic [5:0]  IDX_IRQ2     = 6'h01;
    localparam logic [5:0]  IDX_TIMER    = 6'h03;
    localparam logic [5:0]  IDX_CAP12    = 6'h07;
    localparam logic [5:0]  IDX_CAP78    = 6'h0A;
    localparam logic [5:0]  IDX_FAULT    = 6'h0B;
    localparam logic [5:0]  IDX_OSC      = 6'h10;
    localparam logic [5:0]  IDX_STATUS   = 6'h11;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD   = 3'h2;
    // Selector slot order in the packed selector vector
    localparam int          S_IRQ1 = 0;
    localparam int          S_IRQ2 = 1;
    localparam int          S_T3   = 2;
    localparam int          S_T2   = 3;
    localparam int          S_C2   = 4;
    localparam int          S_C1   = 5;
    localparam int          S_C8   = 6;
    localparam int          S_C7   = 7;
    localparam int          S_FA   = 8;
    typedef enum logic [1:0] {
        KEY_IDLE  = 2'b00,
        KEY_GOT1  = 2'b01,
        KEY_OPEN  = 2'b11
    } ris_key_t;
endpackage

//--- ris_mux.sv
// One selector-driven input multiplexer with a registered output.
// Assumes pin inputs are synchronous to CLOCK.
`timescale 1ns/1ns
module ris_mux #(
    parameter int NPINS = ris_pkg::NUM_PINS
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [NPINS-1:0]         pins,
    input  wire logic [ris_pkg::SEL_W-1:0] sel,
    output logic                          q
);
    import ris_pkg::*;
    typedef struct packed {
        logic out;
    } ris_mux_st_t;
    ris_mux_st_t s_q;
    ris_mux_st_t s_d;
    always_comb begin
        s_d = s_q;
        // Codes above the last pin, reserved or not, read as ground
        if (sel <= SEL_MAX_PIN) begin
            s_d.out = pins[sel];
        end else begin
            s_d.out = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign q = s_q.out;
endmodule

//--- tb_ris_top.sv
// Directed testbench for the remappable input select block over AHB-Lite.
// Assumes a zero-wait slave whose HREADYOUT feeds back as HREADY.
`timescale 1ns/1ns
module tb_ris_top;
    import ris_pkg::*;
    logic        CLOCK;
    logic        RST_N;
    logic        HSEL;
    logic [7:0]  HADDR;
    logic [1:0]  HTRANS;
    logic        HWRITE;
    logic [2:0]  HSIZE;
    logic [31:0] HWDATA;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic        HRESP;
    logic        ONE_WAY_LOCK_CFG;
    logic [25:0] REMAPPABLE_PIN;
    logic [8:0]  periph;
    logic        CONFIG_MISMATCH_RESET;
    logic        PIN_MAP_LOCK;
    logic [31:0] rd;
    int          mismatches;
    int          total_checks;

    ris_top dut (.CLOCK(CLOCK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .ONE_WAY_LOCK_CFG(ONE_WAY_LOCK_CFG), .REMAPPABLE_PIN(REMAPPABLE_PIN),
        .EXTERNAL_IRQ_1(periph[8]), .EXTERNAL_IRQ_2(periph[7]), .TIMER3_EXT_CLOCK(periph[6]),
        .TIMER2_EXT_CLOCK(periph[5]), .CAPTURE_2(periph[4]), .CAPTURE_1(periph[3]),
        .CAPTURE_8(periph[2]), .CAPTURE_7(periph[1]), .COMPARE_FAULT_A(periph[0]),
        .CONFIG_MISMATCH_RESET(CONFIG_MISMATCH_RESET), .PIN_MAP_LOCK(PIN_MAP_LOCK));

    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for hready; a stuck slave ends the run
    task automatic ready_edge();
        int n;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 20);
        if (HREADYOUT !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED hready expected 1 seen %b", HREADYOUT);
            close_out();
        end
    endtask

    task automatic ahb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        HSEL   <= 1'b1;
        HADDR  <= {idx, 2'b00};
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= wr;
        HSIZE  <= HSIZE_WORD;
        ready_edge();
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        ready_edge();
        rd = HRDATA;
    endtask

    function automatic logic pick(input logic [4:0] c, input logic [25:0] p);
        return (c <= SEL_MAX_PIN) ? p[c] : 1'b0;
    endfunction

    task automatic sc_reset_and_mask();
        logic [5:0]  idx [6] = '{IDX_IRQ1, IDX_IRQ2, IDX_TIMER, IDX_CAP12, IDX_CAP78, IDX_FAULT};
        logic [15:0] rv [6] = '{16'h1F00, 16'h001F, 16'h1F1F, 16'h1F1F, 16'h1F1F, 16'h001F};
        chk("outputs after reset", 32'h0, {23'h0, periph});
        for (int i = 0; i < 6; i++) begin
            ahb(1'b0, idx[i], 32'h0);
            chk("reset value", {16'h0, rv[i]}, rd);
            ahb(1'b1, idx[i], ~{16'h0, rv[i]});
            ahb(1'b0, idx[i], 32'h0);
            chk("unimplemented bits", 32'h0, rd);
        end
        ahb(1'b0, 6'h0F, 32'h0);
        chk("unmapped read", 32'h0, rd);
    endtask

    // Distinct high and low codes expose swapped fields, except the 1A/1F and 1F/1E pairs, whose codes all read as ground
    task automatic sc_route();
        logic [4:0] hi [6] = '{5'h03, 5'h00, 5'h19, 5'h1A, 5'h1E, 5'h1F};
        logic [4:0] lo [6] = '{5'h05, 5'h19, 5'h00, 5'h1F, 5'h01, 5'h1E};
        logic [8:0] e;
        logic [4:0] h;
        logic [4:0] l;
        for (int i = 0; i < 12; i++) begin
            h = hi[i / 2];
            l = lo[i / 2];
            REMAPPABLE_PIN <= i[0] ? ~26'h0000009 : 26'h0000009;
            ahb(1'b1, IDX_IRQ1, {19'h0, h, 8'h00});
            ahb(1'b1, IDX_IRQ2, {27'h0, l});
            ahb(1'b1, IDX_TIMER, {19'h0, h, 3'h0, l});
            ahb(1'b1, IDX_CAP12, {19'h0, h, 3'h0, l});
            ahb(1'b1, IDX_FAULT, {27'h0, l});
            ahb(1'b1, IDX_CAP78, {19'h0, h, 3'h0, l});
            @(posedge CLOCK);
            @(negedge CLOCK);
            e = {pick(h, REMAPPABLE_PIN), pick(l, REMAPPABLE_PIN), pick(h, REMAPPABLE_PIN),
                 pick(l, REMAPPABLE_PIN), pick(h, REMAPPABLE_PIN), pick(l, REMAPPABLE_PIN),
                 pick(h, REMAPPABLE_PIN), pick(l, REMAPPABLE_PIN), pick(l, REMAPPABLE_PIN)};
            chk("routing", {23'h0, e}, {23'h0, periph});
            @(posedge CLOCK);
            ahb(1'b0, IDX_CAP78, 32'h0);
            chk("capture 7 8 readback", {19'h0, h, 3'h0, l}, rd);
        end
    endtask

    task automatic key_seq(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] v);
        ahb(1'b1, IDX_OSC, {24'h0, k1});
        ahb(1'b1, IDX_OSC, {24'h0, k2});
        ahb(1'b1, IDX_OSC, {24'h0, v});
        @(posedge CLOCK);
    endtask

    task automatic sc_lock();
        ahb(1'b1, IDX_CAP12, 32'h0000_0102);
        key_seq(KEY_FIRST, KEY_SECOND, 8'h40);
        chk("lock set", 32'h1, {31'h0, PIN_MAP_LOCK});
        ahb(1'b1, IDX_CAP12, 32'h0000_0304);
        chk("locked write response", 32'h0, {31'h0, HRESP});
        ahb(1'b0, IDX_CAP12, 32'h0);
        chk("locked write", 32'h0000_0102, rd);
        ONE_WAY_LOCK_CFG <= 1'b1;
        key_seq(KEY_FIRST, KEY_SECOND, 8'h00);
        chk("one way lock", 32'h1, {31'h0, PIN_MAP_LOCK});
        ONE_WAY_LOCK_CFG <= 1'b0;
        key_seq(KEY_FIRST, 8'h11, 8'h00);
        chk("broken key", 32'h1, {31'h0, PIN_MAP_LOCK});
        key_seq(KEY_FIRST, KEY_SECOND, 8'h00);
        chk("lock cleared", 32'h0, {31'h0, PIN_MAP_LOCK});
        ahb(1'b1, IDX_CAP12, 32'h0000_0304);
        ahb(1'b0, IDX_CAP12, 32'h0);
        chk("unlocked write", 32'h0000_0304, rd);
        chk("no mismatch reset", 32'h0, {31'h0, CONFIG_MISMATCH_RESET});
        ahb(1'b0, IDX_STATUS, 32'h0);
        chk("status", 32'h0, rd);
    endtask

    initial begin
        RST_N = 1'b0;
        HSEL = 1'b0;
        HADDR = 8'h00;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = HSIZE_WORD;
        HWDATA = 32'h0;
        ONE_WAY_LOCK_CFG = 1'b0;
        REMAPPABLE_PIN = 26'h3FFFFFF;
        mismatches = 0;
        total_checks = 0;
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        @(posedge CLOCK);
        sc_reset_and_mask();
        sc_route();
        sc_lock();
        close_out();
    end
endmodule
